// file: src/sdram_pin_command_interface.sv
// sdram pin command and data interface with apb status port
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pin_params.svh"
module sdram_pin_command_interface
  import sdram_pin_pkg::*;
#(
  parameter int DQ_W   = 16,                      // 4, 8 or 16
  parameter int NM     = (DQ_W == 16) ? 2 : 1,    // derived, keep default
  parameter int MEM_AW = 8                        // stored words, log2
)(
  input  wire logic              REF_CLK,         // 50 MHz clock
  input  wire logic              RST_B,           // async reset, low
  input  wire logic              CLOCK_ENABLE_IN, // clock enable pin
  input  wire logic              CHIP_SELECT_N,   // chip select, low
  input  wire logic              ROW_STROBE_N,    // row strobe, low
  input  wire logic              COLUMN_STROBE_N, // column strobe, low
  input  wire logic              WRITE_ENABLE_N,  // write enable, low
  input  wire logic [1:0]        BANK_SELECT,     // bank select
  input  wire logic [12:0]       ADDRESS_BUS,     // row/col/op-code
  input  wire logic [NM-1:0]     DATA_MASK,       // [0] lower, [1] upper
  input  wire logic [DQ_W-1:0]   DATA_IN,         // data pin input
  output logic      [DQ_W-1:0]   DATA_OUT,        // data pin output
  output logic      [NM-1:0]     DATA_OE,         // drive per mask lane
  input  wire logic [11:0]       PADDR,           // apb address
  input  wire logic              PSEL,            // apb select
  input  wire logic              PENABLE,         // apb enable
  input  wire logic              PWRITE,          // apb direction
  input  wire logic [31:0]       PWDATA,          // apb write data
  output logic      [31:0]       PRDATA,          // apb read data
  output logic                   PREADY,          // apb ready
  output logic                   PSLVERR          // apb error
);
  localparam int LW = DQ_W / NM;
  localparam int PW = 5 + 2 + 13 + NM + DQ_W;
  localparam logic [10:0] CMASK = (DQ_W == 16) ? 11'h1ff :
                                  (DQ_W == 8)  ? 11'h3ff : 11'h7ff;
  // strobes idle high out of reset so no false command decodes
  localparam logic [PW-1:0] PIN_RST = {5'h1f, {(PW-5){1'b0}}};

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // column bits by width
  function automatic logic [10:0] col_of(input logic [12:0] a);
    logic [10:0] c;
    c = {a[`COL_HI_BIT], a[9:0]};
    return c & CMASK;
  endfunction

  // burst length to wrap mask
  function automatic logic [10:0] bl_mask(input logic [2:0] bl);
    logic [10:0] m;
    case (bl)
      3'h0:     m = 11'h000;
      3'h1:     m = 11'h001;
      3'h2:     m = 11'h003;
      3'h3:     m = 11'h007;
      `BL_FULL: m = CMASK;
      default:  m = 11'h000;
    endcase
    return m;
  endfunction

  // next column, wrapping inside the burst block
  function automatic logic [10:0] col_step(input logic [10:0] c,
                                           input logic [10:0] m);
    logic [10:0] n;
    n = c + 11'h001;
    return (c & ~m) | (n & m);
  endfunction

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0]      rst_ff;
  logic            rst_n;
  logic [PW-1:0]   s1_ff;
  logic [PW-1:0]   s2_ff;
  logic            cke_s, cs_s, ras_s, cas_s, we_s;
  logic [1:0]      ba_s;
  logic [12:0]     adr_s;
  logic [NM-1:0]   msk_s;
  logic [DQ_W-1:0] din_s;

  // reset leaves through two flops
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) rst_ff <= 2'h0;
    else        rst_ff <= {rst_ff[0], 1'b1};
  end
  assign rst_n = rst_ff[1];

  // rising edge capture of every pin, two stages
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= PIN_RST;
      s2_ff <= PIN_RST;
    end else begin
      s1_ff <= {CLOCK_ENABLE_IN, CHIP_SELECT_N, ROW_STROBE_N,
                COLUMN_STROBE_N, WRITE_ENABLE_N, BANK_SELECT,
                ADDRESS_BUS, DATA_MASK, DATA_IN};
      s2_ff <= s1_ff;
    end
  end
  assign {cke_s, cs_s, ras_s, cas_s, we_s, ba_s, adr_s, msk_s, din_s} = s2_ff;

  // ---------------------------------------------------------------
  // command decode and power state
  // ---------------------------------------------------------------
  pw_state_type pw_ff, nxt_pw;
  cmd_type      cmd;
  logic         act, cmd_ok, ctrl_en_ff;
  logic         bst_ff;
  logic [3:0]   open_ff;

  // four strobes registered together form one command
  assign cmd = cs_s ? CMD_DESEL : cmd_type'({1'b0, ras_s, cas_s, we_s});
  assign act    = (pw_ff == PW_RUN) && cke_s;
  assign cmd_ok = act && ctrl_en_ff;

  // gating choice depends on what is in flight
  always_comb begin
    nxt_pw = pw_ff;
    case (pw_ff)
      PW_RUN: begin
        if (!cke_s) begin
          if (bst_ff)                    nxt_pw = PW_SUSP;
          else if (open_ff != 4'h0)      nxt_pw = PW_APD;
          else if (ctrl_en_ff && cmd == CMD_REF) nxt_pw = PW_SREF;
          else                           nxt_pw = PW_PPD;
        end
      end
      // only the synchronised enable is watched while parked
      default: begin
        if (cke_s) nxt_pw = PW_RUN;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) pw_ff <= PW_RUN;
    else        pw_ff <= nxt_pw;
  end

  // ---------------------------------------------------------------
  // bank rows, mode register and burst engine
  // ---------------------------------------------------------------
  logic [12:0] row_ff [4];
  logic [12:0] nxt_row [4];
  logic [3:0]  nxt_open;
  logic [12:0] mode_ff, nxt_mode;
  logic        nxt_bst, bwr_ff, nxt_bwr, bap_ff, nxt_bap;
  logic        bfull_ff, nxt_bfull;
  logic [1:0]  bbank_ff, nxt_bbank;
  logic [10:0] bcol_ff, nxt_bcol, bcnt_ff, nxt_bcnt;
  logic [10:0] bmask, acc_col;
  logic [1:0]  acc_bank;
  logic        start, acc, acc_wr, end_now, ap_end, stop;

  assign bmask = bl_mask(mode_ff[2:0]);
  assign start = cmd_ok && (cmd == CMD_RD || cmd == CMD_WR) && open_ff[ba_s];
  assign stop  = cmd_ok && cmd == CMD_BST;
  assign acc      = act && (start || bst_ff);
  assign acc_wr   = start ? (cmd == CMD_WR) : bwr_ff;
  assign acc_bank = start ? ba_s : bbank_ff;
  assign acc_col  = start ? col_of(adr_s) : bcol_ff;
  assign end_now  = start ? (bmask == 11'h000)
                          : (bst_ff && !bfull_ff && bcnt_ff == 11'h001 && !stop);
  assign ap_end   = act && end_now && (start ? adr_s[`AP_BIT] : bap_ff);

  always_comb begin
    nxt_row   = row_ff;
    nxt_open  = open_ff;
    nxt_mode  = mode_ff;
    nxt_bst   = bst_ff;
    nxt_bwr   = bwr_ff;
    nxt_bap   = bap_ff;
    nxt_bfull = bfull_ff;
    nxt_bbank = bbank_ff;
    nxt_bcol  = bcol_ff;
    nxt_bcnt  = bcnt_ff;
    if (act) begin
      if (start) begin
        nxt_bst   = (bmask != 11'h000);
        nxt_bwr   = (cmd == CMD_WR);
        nxt_bbank = ba_s;
        nxt_bfull = (mode_ff[2:0] == `BL_FULL);
        nxt_bap   = adr_s[`AP_BIT] && (mode_ff[2:0] != `BL_FULL);
        nxt_bcol  = col_step(col_of(adr_s), bmask);
        nxt_bcnt  = bmask;
      end else if (bst_ff) begin
        if (stop) begin
          nxt_bst = 1'b0;
        end else begin
          nxt_bcol = col_step(bcol_ff, bmask);
          if (!bfull_ff) begin
            nxt_bcnt = bcnt_ff - 11'h001;
            if (bcnt_ff == 11'h001) nxt_bst = 1'b0;
          end
        end
      end
      if (ap_end) nxt_open[acc_bank] = 1'b0;
      if (cmd_ok) begin
        case (cmd)
          CMD_ACT: begin
            nxt_open[ba_s] = 1'b1;
            nxt_row[ba_s]  = adr_s;
          end
          CMD_PRE: begin
            if (adr_s[`AP_BIT]) nxt_open = 4'h0;
            else                nxt_open[ba_s] = 1'b0;
          end
          CMD_LMR: nxt_mode = adr_s;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      row_ff   <= '{default: 13'h0000};
      open_ff  <= 4'h0;
      mode_ff  <= `MODE_RST;
      bst_ff   <= 1'b0;
      bwr_ff   <= 1'b0;
      bap_ff   <= 1'b0;
      bfull_ff <= 1'b0;
      bbank_ff <= 2'h0;
      bcol_ff  <= 11'h000;
      bcnt_ff  <= 11'h000;
    end else begin
      row_ff   <= nxt_row;
      open_ff  <= nxt_open;
      mode_ff  <= nxt_mode;
      bst_ff   <= nxt_bst;
      bwr_ff   <= nxt_bwr;
      bap_ff   <= nxt_bap;
      bfull_ff <= nxt_bfull;
      bbank_ff <= nxt_bbank;
      bcol_ff  <= nxt_bcol;
      bcnt_ff  <= nxt_bcnt;
    end
  end

  // ---------------------------------------------------------------
  // storage and data path
  // ---------------------------------------------------------------
  // only the low key bits (bank, then column) are kept, so at MEM_AW 8 every row of a bank aliases
  logic [DQ_W-1:0]   mem [2**MEM_AW];
  logic [MEM_AW-1:0] idx;
  logic [25:0]       key;
  logic [DQ_W-1:0]   old_word, nxt_word;
  logic              wr_en;
  logic [DQ_W-1:0]   rd0_ff, dout_ff, nxt_rd0, nxt_dout;
  logic [NM-1:0]     oe0_ff, oe1_ff, nxt_oe0, nxt_oe1;

  assign key      = {row_ff[acc_bank], acc_col, acc_bank};
  assign idx      = key[MEM_AW-1:0];
  assign old_word = mem[idx];
  assign wr_en    = acc && acc_wr;

  // masked lanes keep their stored bits, one mask per lane
  always_comb begin
    nxt_word = old_word;
    for (int l = 0; l < NM; l++) begin
      if (!msk_s[l]) nxt_word[l*LW +: LW] = din_s[l*LW +: LW];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (wr_en) mem[idx] <= nxt_word;
  end

  // two output stages; they hold while the clock is gated
  always_comb begin
    nxt_rd0  = rd0_ff;
    nxt_oe0  = oe0_ff;
    nxt_dout = dout_ff;
    nxt_oe1  = oe1_ff;
    if (act) begin
      nxt_rd0  = old_word;
      nxt_dout = rd0_ff;
      nxt_oe1  = oe0_ff;
      for (int l = 0; l < NM; l++) begin
        nxt_oe0[l] = acc && !acc_wr && !msk_s[l];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rd0_ff  <= '0;
      dout_ff <= '0;
      oe0_ff  <= '0;
      oe1_ff  <= '0;
    end else begin
      rd0_ff  <= nxt_rd0;
      dout_ff <= nxt_dout;
      oe0_ff  <= nxt_oe0;
      oe1_ff  <= nxt_oe1;
    end
  end

  assign DATA_OUT = dout_ff;
  assign DATA_OE  = oe1_ff;

  // ---------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------
  logic [31:0] prdata_ff, nxt_prdata;
  logic        nxt_en, hit;

  assign hit = (PADDR == `OFS_CTRL) || (PADDR == `OFS_STATUS) ||
               (PADDR == `OFS_MODE);

  // read data is loaded in setup so it is a flop in access
  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_en     = ctrl_en_ff;
    if (PSEL && !PENABLE) begin
      nxt_prdata = 32'h0000_0000;
      if (PADDR == `OFS_CTRL) begin
        nxt_prdata[`CTRL_EN_BIT] = ctrl_en_ff;
      end else if (PADDR == `OFS_STATUS) begin
        nxt_prdata[`ST_PW_LSB +: 3] = pw_ff;
        nxt_prdata[`ST_BURST_BIT]   = bst_ff;
        nxt_prdata[`ST_OPEN_LSB +: 4] = open_ff;
        nxt_prdata[`ST_WR_BIT]      = bwr_ff;
      end else if (PADDR == `OFS_MODE) begin
        nxt_prdata[12:0] = mode_ff;
      end
    end
    if (PSEL && PENABLE && PWRITE && PADDR == `OFS_CTRL) begin
      nxt_en = PWDATA[`CTRL_EN_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff  <= 32'h0000_0000;
      ctrl_en_ff <= `CTRL_RST;
    end else begin
      prdata_ff  <= nxt_prdata;
      ctrl_en_ff <= nxt_en;
    end
  end

  assign PRDATA  = prdata_ff;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  sequence rd_masked;
    act && acc && !acc_wr && msk_s[0];
  endsequence

  gate_hold_a:
    assert property (!act |=> $stable(bcol_ff) && $stable(dout_ff))
      else $error("state moved while clock gated");
  pd_enter_a:
    assert property (pw_ff == PW_RUN && !cke_s && !bst_ff && open_ff != 4'h0
                     |=> pw_ff == PW_APD)
      else $error("active power-down not entered");
  pd_exit_a:
    assert property (pw_ff != PW_RUN && cke_s |=> pw_ff == PW_RUN)
      else $error("power mode not left on enable");
  pd_ignore_a:
    assert property (pw_ff != PW_RUN |=> $stable(open_ff) && $stable(mode_ff))
      else $error("input acted on while parked");
  cs_mask_a:
    assert property (act && cs_s && !bst_ff |=> !bst_ff)
      else $error("command taken with chip select high");
  cs_burst_a:
    assert property (act && cs_s && bst_ff && !bfull_ff && bcnt_ff > 11'h001
                     |=> bst_ff)
      else $error("burst dropped by chip select");
  mask_hiz_a:
    assert property (rd_masked ##1 act |=> !DATA_OE[0])
      else $error("masked read still driven after two edges");
  row_latch_a:
    assert property (cmd_ok && cmd == CMD_ACT |=>
                     open_ff[$past(ba_s)] && row_ff[$past(ba_s)] == $past(adr_s))
      else $error("row not latched on activate");
  pre_all_a:
    assert property (cmd_ok && cmd == CMD_PRE && adr_s[`AP_BIT] |=> open_ff == 4'h0)
      else $error("precharge all left a bank open");
  lmr_a:
    assert property (cmd_ok && cmd == CMD_LMR |=> mode_ff == $past(adr_s))
      else $error("mode register not loaded");
endmodule
`default_nettype wire

// file: src/sdram_pin_params.svh
// constants for the sdram pin command interface
`ifndef SDRAM_PIN_PARAMS_SVH
`define SDRAM_PIN_PARAMS_SVH
`define OFS_CTRL     12'h000
`define OFS_STATUS   12'h004
`define OFS_MODE     12'h008
`define CTRL_EN_BIT  0
`define CTRL_RST     1'b1
`define MODE_RST     13'h0000
`define ST_PW_LSB    0
`define ST_BURST_BIT 3
`define ST_OPEN_LSB  4
`define ST_WR_BIT    8
`define AP_BIT       10
`define COL_HI_BIT   11
`define BL_FULL      3'h7
`endif

// file: src/sdram_pin_pkg.sv
// types for the sdram pin command interface
`default_nettype none
package sdram_pin_pkg;
  // power state, gray along run/suspend/active pd/precharge pd/self refresh
  typedef enum logic [2:0] {
    PW_RUN  = 3'h0,
    PW_SUSP = 3'h1,
    PW_APD  = 3'h3,
    PW_PPD  = 3'h2,
    PW_SREF = 3'h6
  } pw_state_type;
  // {chip select, row, column, write} strobes as registered
  typedef enum logic [3:0] {
    CMD_LMR   = 4'h0,
    CMD_REF   = 4'h1,
    CMD_PRE   = 4'h2,
    CMD_ACT   = 4'h3,
    CMD_WR    = 4'h4,
    CMD_RD    = 4'h5,
    CMD_BST   = 4'h6,
    CMD_NOP   = 4'h7,
    CMD_DESEL = 4'h8
  } cmd_type;
endpackage
`default_nettype wire

// file: test/sdram_ctrl_model.sv
// memory controller model that drives the sdram pins
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
  import sdram_pin_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int NM   = 2
)(
  input  wire logic            clk,    // pin clock
  output logic                 cke,    // clock enable
  output logic                 cs_n,   // chip select
  output logic                 ras_n,  // row strobe
  output logic                 cas_n,  // column strobe
  output logic                 we_n,   // write enable
  output logic [1:0]           ba,     // bank select
  output logic [12:0]          addr,   // address bus
  output logic [NM-1:0]        dqm,    // byte masks
  output logic [DQ_W-1:0]      dq_in,  // resolved data line
  input  wire logic [DQ_W-1:0] dq_out, // device data
  input  wire logic [NM-1:0]   dq_oe   // device drive per lane
);
  logic [DQ_W-1:0] wd;
  logic            drv;
  logic [DQ_W-1:0] last_ff;
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
    ba = 2'h0;
    addr = 13'h0000;
    dqm = {NM{1'b0}};
    wd = {DQ_W{1'b0}};
    drv = 1'b0;
    last_ff = {DQ_W{1'b0}};
  end
  // one pin cycle: everything changes together just after the edge
  task automatic drive(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic [NM-1:0] m, input logic [DQ_W-1:0] d,
                       input logic dv, input logic ce);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    dqm <= m;
    wd <= d;
    drv <= dv;
    cke <= ce;
  endtask
  // undriven line shows the inverse of its last level, never a stale copy
  always_comb begin
    for (int i = 0; i < DQ_W; i++) begin
      if (drv) dq_in[i] = wd[i];
      else if (dq_oe[(NM == 2) ? i / 8 : 0]) dq_in[i] = dq_out[i];
      else dq_in[i] = ~last_ff[i];
    end
  end
  always @(posedge clk) last_ff <= dq_in;
endmodule
`default_nettype wire

// file: test/tb_sdram_pin_command_interface.sv
// self-checking bench for the sdram pin command interface
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_pin_command_interface;
  import sdram_pin_pkg::*;
  localparam int DQ_W = 16;
  localparam int NM   = 2;
  logic            clk, rst_b, psel, penable, pwrite, pready, pslverr, err, cke_v;
  logic            cke, cs_n, ras_n, cas_n, we_n;
  logic [1:0]      ba, pba;
  logic [11:0]     paddr;
  logic [12:0]     row, col, paddr_pin;
  logic [31:0]     pwdata, prdata, rd;
  logic [NM-1:0]   dqm, oe, acc;
  logic [DQ_W-1:0] dq_in, dq_out, d0, d1, e0, e1;
  logic [NM-1:0]   oe_log [0:9];
  logic [DQ_W-1:0] out_log [0:9];
  integer          seed, num_errors, check_count, cycles;

  sdram_pin_command_interface #(.DQ_W(DQ_W)) sdram_pin_command_interface_i (
    .REF_CLK(clk), .RST_B(rst_b), .CLOCK_ENABLE_IN(cke), .CHIP_SELECT_N(cs_n),
    .ROW_STROBE_N(ras_n), .COLUMN_STROBE_N(cas_n), .WRITE_ENABLE_N(we_n),
    .BANK_SELECT(pba), .ADDRESS_BUS(paddr_pin), .DATA_MASK(dqm), .DATA_IN(dq_in),
    .DATA_OUT(dq_out), .DATA_OE(oe), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  sdram_ctrl_model #(.DQ_W(DQ_W), .NM(NM)) sdram_ctrl_model_i (
    .clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(pba), .addr(paddr_pin), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(oe));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // apb transfer, held until pready is seen at a rising edge
  // only the bench timeout ends a wait for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pin(input logic [3:0] c, input logic [12:0] a, input logic [NM-1:0] m,
                     input logic [DQ_W-1:0] d, input logic dv);
    sdram_ctrl_model_i.drive(c, ba, a, m, d, dv, cke_v);
  endtask
  task automatic nops(input int n);
    repeat (n) pin(CMD_NOP, 13'h0000, 2'b00, 16'h0000, 1'b0);
  endtask
  // ten pin cycles: command, then idles; outputs logged after each edge
  task automatic burst(input logic [3:0] c, input logic [12:0] a, input logic [NM-1:0] m1,
                       input logic [DQ_W-1:0] w0, input logic [DQ_W-1:0] w1,
                       input logic dv, input logic [3:0] idle);
    for (int k = 0; k < 10; k++) begin
      pin((k == 0) ? c : idle, (k == 0) ? a : 13'h0000, (k == 1) ? m1 : 2'b00,
          (k == 0) ? w0 : w1, dv && k < 2);
      #1;
      oe_log[k] = oe;
      out_log[k] = dq_out;
    end
  endtask
  // expected word after a masked write over an older one
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] wm);
    merge = {wm[1] ? old[15:8] : nw[15:8], wm[0] ? old[7:0] : nw[7:0]};
  endfunction
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'hc393;
    {num_errors, check_count, cycles} = 0;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    cke_v = 1'b1;
    ba = 2'h0;
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    nops(4);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("test registers done");
    pin(CMD_LMR, 13'h0001, 2'b00, 16'h0000, 1'b0);
    nops(4);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h1);
    $display("test mode load done");
    ba = 2'($random(seed));
    row = 13'($random(seed));
    col = 13'($random(seed)) & 13'h01fe;
    {d0, d1} = $random(seed);
    {e0, e1} = $random(seed);
    pin(CMD_ACT, row, 2'b00, 16'h0000, 1'b0);
    nops(4);
    apb(1'b0, 12'h004, 32'h0);
    check({28'h0, rd[7:4]}, {28'h0, 4'h1 << ba});
    // plain write, then a rewrite masking the upper byte of its second beat
    burst(CMD_WR, col, 2'b00, d0, d1, 1'b1, CMD_NOP);
    burst(CMD_WR, col, 2'b10, e0, e1, 1'b1, CMD_NOP);
    // read with column bit 9 set and chip deselected while the burst runs
    burst(CMD_RD, col | 13'h0200, 2'b01, 16'h0000, 16'h0000, 1'b0, CMD_DESEL);
    check({30'h0, oe_log[4]}, 32'h3);
    check({16'h0, out_log[4]}, {16'h0, e0});
    check({30'h0, oe_log[5]}, 32'h2);
    check({16'h0, out_log[5] & 16'hff00}, {16'h0, merge(d1, e1, 2'b10) & 16'hff00});
    check({30'h0, oe_log[6]}, 32'h0);
    $display("test masked burst done");
    burst(4'hd, col, 2'b00, 16'h0000, 16'h0000, 1'b0, CMD_NOP);
    acc = 2'b00;
    for (int k = 0; k < 10; k++) acc = acc | oe_log[k];
    check({30'h0, acc}, 32'h0);
    $display("test deselected read done");
    cke_v = 1'b0;
    nops(4);
    apb(1'b0, 12'h004, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, PW_APD});
    cke_v = 1'b1;
    nops(4);
    apb(1'b0, 12'h004, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, PW_RUN});
    $display("test clock gating done");
    burst(CMD_RD, col | 13'h0400, 2'b00, 16'h0000, 16'h0000, 1'b0, CMD_NOP);
    check({16'h0, out_log[4]}, {16'h0, e0});
    apb(1'b0, 12'h004, 32'h0);
    check({28'h0, rd[7:4]}, 32'h0);
    $display("test auto precharge done");
    pin(CMD_ACT, row, 2'b00, 16'h0000, 1'b0);
    ba = ba ^ 2'h1;
    pin(CMD_ACT, row, 2'b00, 16'h0000, 1'b0);
    ba = ba ^ 2'h1;
    nops(3);
    pin(CMD_PRE, 13'h0000, 2'b00, 16'h0000, 1'b0);
    nops(4);
    apb(1'b0, 12'h004, 32'h0);
    check({28'h0, rd[7:4]}, {28'h0, 4'h1 << (ba ^ 2'h1)});
    pin(CMD_PRE, 13'h0400, 2'b00, 16'h0000, 1'b0);
    nops(4);
    apb(1'b0, 12'h004, 32'h0);
    check({28'h0, rd[7:4]}, 32'h0);
    cke_v = 1'b0;
    nops(4);
    apb(1'b0, 12'h004, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, PW_PPD});
    cke_v = 1'b1;
    nops(4);
    $display("test precharge done");
    // decode disabled: an activate must leave every bank closed
    apb(1'b1, 12'h000, 32'h0);
    pin(CMD_ACT, row, 2'b00, 16'h0000, 1'b0);
    nops(4);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check({28'h0, rd[7:4]}, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    $display("test decode disable done");
    // refresh with enable low parks in self refresh; an activate there is lost
    cke_v = 1'b0;
    pin(CMD_REF, 13'h0000, 2'b00, 16'h0000, 1'b0);
    pin(CMD_ACT, row, 2'b00, 16'h0000, 1'b0);
    nops(3);
    apb(1'b0, 12'h004, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, PW_SREF});
    cke_v = 1'b1;
    nops(4);
    apb(1'b0, 12'h004, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, PW_RUN});
    check({28'h0, rd[7:4]}, 32'h0);
    $display("test self refresh done");
    // burst of four runs to its end with chip deselected
    pin(CMD_LMR, 13'h0002, 2'b00, 16'h0000, 1'b0);
    pin(CMD_ACT, row, 2'b00, 16'h0000, 1'b0);
    nops(3);
    burst(CMD_RD, col, 2'b00, 16'h0000, 16'h0000, 1'b0, CMD_DESEL);
    check({30'h0, oe_log[7]}, 32'h3);
    check({16'h0, out_log[5]}, {16'h0, merge(d1, e1, 2'b10)});
    check({30'h0, oe_log[8]}, 32'h0);
    $display("test burst of four done");
    // enable dropped in mid burst suspends it; the burst resumes after
    pin(CMD_RD, col, 2'b00, 16'h0000, 1'b0);
    cke_v = 1'b0;
    nops(4);
    apb(1'b0, 12'h004, 32'h0);
    check({28'h0, rd[3:0]}, {28'h0, 1'b1, PW_SUSP});
    cke_v = 1'b1;
    nops(6);
    apb(1'b0, 12'h004, 32'h0);
    check({28'h0, rd[3:0]}, 32'h0);
    $display("test clock suspend done");
    // full page read cut short by a terminate
    pin(CMD_LMR, 13'h0007, 2'b00, 16'h0000, 1'b0);
    burst(CMD_RD, col, 2'b00, 16'h0000, 16'h0000, 1'b0, CMD_BST);
    check({30'h0, oe_log[5]}, 32'h3);
    check({30'h0, oe_log[6]}, 32'h0);
    $display("test burst terminate done");
    end_sim();
  end
endmodule
`default_nettype wire
